// >>> test/host_model.sv
// host side model: byte writes and reads on the register port
// assumes the bench calls its tasks; strobes change at the falling edge
`timescale 1ns/100ps
module host_model (
   // clock
   input wire logic ref_clk,
   // register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one access, held through the taking edge, then one idle cycle
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = ~d; // released data is scrambled so nothing relies on it
   endtask
   function automatic logic [23:0] fword(input real fsc, input logic up);
      real r;
      r = 67108864.0 * fsc / 27.0e6;
      return up ? 24'($ceil(r)) : 24'($floor(r));
   endfunction
   task automatic load(input real fsc, input logic up, input logic [7:0] adj);
      logic [23:0] f;
      f = fword(fsc, up);
      acc(8'h08, adj, 1'b1);
      for (int i = 0; i < 3; i++) acc(8'h09 + 8'(i), f[23-8*i -: 8], 1'b1);
   endtask
endmodule // host_model

// >>> test/testbench.sv
// self-checking bench for the upper register bank and subcarrier oscillator
// assumes host_model on the register port; a field is shortened to 2 lines
`timescale 1ns/100ps
module testbench;
   localparam logic [7:0] ofs [14] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'hf0, 8'hf1, 8'hf2,
      8'hf3, 8'hf4, 8'hf8, 8'hf9, 8'hfb, 8'hfc, 8'hff};
   localparam logic [7:0] rv [14] = '{8'h99, 8'h87, 8'hc1, 8'hf1, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h7e, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] msk [14] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h7f,
      8'h7f, 8'h0f, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] video_format = 2'd0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, port_write_out, caption_control_out;
   logic [7:0] genlock_control_out;
   logic reg_wr, reg_rd, line_end_out;
   logic rd_d = 1'b0;
   logic [25:0] subcarrier_phase;
   logic [9:0] hsync_offset_out;
   logic [7:0] exp_q [$];
   logic [7:0] wv [14];
   int n_errors = 0;
   int n_checks = 0;
   int seed = 42;
   host_model i_host_model (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   nco_upper_regs #(.PHASE_W(26), .LINES_525(2), .LINES_625(2)) i_nco_upper_regs (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .video_format(video_format),
      .subcarrier_phase(subcarrier_phase), .line_end_out(line_end_out),
      .port_write_out(port_write_out), .caption_control_out(caption_control_out),
      .hsync_offset_out(hsync_offset_out), .genlock_control_out(genlock_control_out));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // read data is registered, so it is compared the cycle after the taking edge
   always @(posedge ref_clk) rd_d <= reg_rd;
   always @(negedge ref_clk) begin
      if (rd_d && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
   end
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host_model.acc(a, 8'h00, 1'b0);
   endtask
   task automatic rdf(input logic [23:0] f);
      for (int i = 0; i < 3; i++) rd(8'h09 + 8'(i), f[23-8*i -: 8]);
   endtask
   task automatic next_le(output logic [25:0] ph, output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (line_end_out !== 1'b1 && n < 4000);
      ph = subcarrier_phase;
   endtask
   // 16 lines hold exactly one 8-field boundary, so one adjust lands in the span
   task automatic span(input int len, input logic [23:0] f, input logic [7:0] a);
      logic [25:0] p0, p1;
      int n;
      next_le(p0, n);
      next_le(p0, n);
      for (int i = 0; i < 16; i++) next_le(p1, n);
      chk(n, len);
      chk(26'(p1 - p0), 26'(64'(len) * 16 * f + a));
   endtask
   initial begin
      logic [25:0] p0, p1;
      int n;
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 0; i < 14; i++) rd(ofs[i], rv[i]);
      rd(8'h22, 8'h00);
      rd(8'h30, 8'h00);
      chk(hsync_offset_out, 32'h07e);
      for (int i = 0; i < 14; i++) begin
         wv[i] = 8'($random(seed));
         i_host_model.acc(ofs[i], wv[i], 1'b1);
         rd(ofs[i], wv[i] & msk[i]);
      end
      chk(hsync_offset_out, {wv[10][1:0], wv[9]});
      chk(caption_control_out, wv[8] & 8'h0f);
      chk(genlock_control_out, wv[13]);
      i_host_model.acc(8'h22, wv[0], 1'b1);
      i_host_model.acc(8'hfe, 8'hff, 1'b1);
      chk(port_write_out, wv[0]);
      rd(8'h22, 8'h00);
      rd(8'hfe, 8'h00);
      $display("register tests done");
      i_host_model.acc(8'hfb, 8'h00, 1'b1);
      i_host_model.load(3.57954545e6, 1'b1, 8'h3c);
      rdf(24'h87c1f1);
      next_le(p0, n);
      next_le(p0, n);
      next_le(p1, n);
      chk(n, 1716);
      chk(p1, p0);
      i_host_model.acc(8'hfb, 8'h80, 1'b1);
      span(1716, 24'h87c1f1, 8'h3c);
      $display("ntsc tests done");
      i_host_model.acc(8'hfb, 8'h00, 1'b1);
      i_host_model.load(3.58205625e6, 1'b0, 8'h57);
      rdf(24'h87da51);
      i_host_model.load(4.43361875e6, 1'b0, 8'h9c);
      rdf(24'ha8262b);
      rd(8'h08, 8'h9c);
      video_format = 2'd1;
      span(1728, 24'ha8262b, 8'h9c);
      $display("pal tests done");
      tally_and_finish();
   end
   // the run needs about 68000 cycles; 80000 leaves margin and stays under the cap
   initial begin
      #1600000;
      n_errors++;
      tally_and_finish();
   end
endmodule // testbench

// >>> verilog/nco_consts.svh
// constants for the subcarrier oscillator and upper register bank
// assumes inclusion by bare name from the two modules; the package does not include it
`ifndef NCO_CONSTS_SVH
`define NCO_CONSTS_SVH
`define OFS_ADJUST 8'h08
`define OFS_FREQ2 8'h09
`define OFS_FREQ1 8'h0a
`define OFS_FREQ0 8'h0b
`define OFS_PORT_WR 8'h22
`define OFS_CAP_F1B1 8'hf0
`define OFS_CAP_F1B2 8'hf1
`define OFS_CAP_F2B1 8'hf2
`define OFS_CAP_F2B2 8'hf3
`define OFS_CAP_CTL 8'hf4
`define OFS_HSOFF_LO 8'hf8
`define OFS_HSOFF_HI 8'hf9
`define OFS_SLAVE_CTL 8'hfb
`define OFS_SLAVE_POS 8'hfc
`define OFS_TEST 8'hfe
`define OFS_GENLOCK 8'hff
`define RST_ADJUST 8'h99
`define RST_FREQ2 8'h87
`define RST_FREQ1 8'hc1
`define RST_FREQ0 8'hf1
`define RST_HSOFF_LO 8'h7e
`define RST_ZERO 8'h00
`define BIT_LINE_RST_DIS 7
`define MASK_CAP_CTL 8'h0f
`define MASK_HI2 8'h03
`define MASK_CAP_DATA 8'h7f
`define PIX_PER_LINE_525 11'd1716
`define PIX_PER_LINE_625 11'd1728
`define FIELDS_PER_ADJ 3'd7
`endif

// >>> verilog/nco_pkg.sv
// types shared by the register bank and the oscillator
// needs nothing from nco_consts.svh; only the modules include it
package nco_pkg;
   typedef enum logic [1:0] {STD_NTSC, STD_PAL, STD_RSVD2, STD_RSVD3} video_std_e;
   typedef struct packed {
      logic [23:0] freq_word;
      logic [7:0] adjust;
      logic line_reset_disable;
      logic is_ntsc;
   } nco_cfg_s;
endpackage

// >>> verilog/nco_upper_regs.sv
// upper register bank with subcarrier oscillator and line timing
// Summary of operation
// - adjust value added to oscillator once every 8 fields, lost when that field end also resets the NTSC oscillator
// - in NTSC the oscillator resets at each line end
// - line reset disable bit suppresses that per-line reset
// - 1716 pixel clocks per line in 525, 1728 in 625
// - 24-bit word built from three bytes, lowest address is MSB
// - adjust register seeds the frequency correction
// assumes a serial bus front end presents byte writes and reads by address
`timescale 1ns/100ps
`include "nco_consts.svh"
module nco_upper_regs import nco_pkg::*; #(
   parameter int PHASE_W = 10,
   parameter int LINES_525 = 525,
   parameter int LINES_625 = 625
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // format
   input wire logic [1:0] video_format,
   // outputs
   output logic [PHASE_W-1:0] subcarrier_phase,
   output logic line_end_out,
   output logic [7:0] port_write_out,
   output logic [7:0] caption_control_out,
   output logic [9:0] hsync_offset_out,
   output logic [7:0] genlock_control_out
);
   logic [7:0] adj_reg, fr2_reg, fr1_reg, fr0_reg, pw_reg;
   logic [7:0] cf1a_reg, cf1b_reg, cf2a_reg, cf2b_reg, cctl_reg;
   logic [7:0] hlo_reg, hhi_reg, sl1_reg, sl2_reg, gps_reg;
   logic [7:0] rdata_reg, rdata_next;
   logic [10:0] pix_reg, pix_next;
   logic [9:0] line_reg, line_next;
   logic [PHASE_W-1:0] ph_reg;
   logic [PHASE_W-1:0] ph_w;
   logic le_reg;
   logic [10:0] run_reg;
   logic run_ok_reg;
   logic [1:0] fmt_reg;
   nco_cfg_s cfg;
   wire is_ntsc = (video_format == STD_NTSC);
   wire [10:0] line_len = is_ntsc ? `PIX_PER_LINE_525 : `PIX_PER_LINE_625;
   wire [9:0] nlines = is_ntsc ? 10'(LINES_525) : 10'(LINES_625);
   wire line_end = (pix_reg == line_len - 11'd1);
   wire field_end = line_end && (line_reg == nlines - 10'd1);
   assign pix_next = line_end ? 11'h0 : pix_reg + 11'd1;
   assign line_next = field_end ? 10'h0 : (line_end ? line_reg + 10'd1 : line_reg);
   // one driver for the whole carrier; field order follows nco_cfg_s
   assign cfg = {fr2_reg, fr1_reg, fr0_reg,
      adj_reg,
      sl1_reg[`BIT_LINE_RST_DIS],
      is_ntsc};
   subcarrier_nco #(.PHASE_W(PHASE_W)) u_nco (
      .ref_clk(ref_clk),
      .rst(rst),
      .cfg(cfg),
      .line_end(line_end),
      .field_end(field_end),
      .phase(ph_w)
   );
   // write decode
   wire w_adj = reg_wr && reg_addr == `OFS_ADJUST;
   wire w_fr2 = reg_wr && reg_addr == `OFS_FREQ2;
   wire w_fr1 = reg_wr && reg_addr == `OFS_FREQ1;
   wire w_fr0 = reg_wr && reg_addr == `OFS_FREQ0;
   wire w_pw = reg_wr && reg_addr == `OFS_PORT_WR;
   wire w_c1a = reg_wr && reg_addr == `OFS_CAP_F1B1;
   wire w_c1b = reg_wr && reg_addr == `OFS_CAP_F1B2;
   wire w_c2a = reg_wr && reg_addr == `OFS_CAP_F2B1;
   wire w_c2b = reg_wr && reg_addr == `OFS_CAP_F2B2;
   wire w_cct = reg_wr && reg_addr == `OFS_CAP_CTL;
   wire w_hlo = reg_wr && reg_addr == `OFS_HSOFF_LO;
   wire w_hhi = reg_wr && reg_addr == `OFS_HSOFF_HI;
   wire w_sl1 = reg_wr && reg_addr == `OFS_SLAVE_CTL;
   wire w_sl2 = reg_wr && reg_addr == `OFS_SLAVE_POS;
   wire w_gps = reg_wr && reg_addr == `OFS_GENLOCK;
   // read decode; port write data is write-only, test and unmapped read zero
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd) begin
         if (reg_addr == `OFS_ADJUST) rdata_next = adj_reg;
         else if (reg_addr == `OFS_FREQ2) rdata_next = fr2_reg;
         else if (reg_addr == `OFS_FREQ1) rdata_next = fr1_reg;
         else if (reg_addr == `OFS_FREQ0) rdata_next = fr0_reg;
         else if (reg_addr == `OFS_CAP_F1B1) rdata_next = cf1a_reg;
         else if (reg_addr == `OFS_CAP_F1B2) rdata_next = cf1b_reg;
         else if (reg_addr == `OFS_CAP_F2B1) rdata_next = cf2a_reg;
         else if (reg_addr == `OFS_CAP_F2B2) rdata_next = cf2b_reg;
         else if (reg_addr == `OFS_CAP_CTL) rdata_next = cctl_reg;
         else if (reg_addr == `OFS_HSOFF_LO) rdata_next = hlo_reg;
         else if (reg_addr == `OFS_HSOFF_HI) rdata_next = hhi_reg;
         else if (reg_addr == `OFS_SLAVE_CTL) rdata_next = sl1_reg;
         else if (reg_addr == `OFS_SLAVE_POS) rdata_next = sl2_reg;
         else if (reg_addr == `OFS_GENLOCK) rdata_next = gps_reg;
         else rdata_next = `RST_ZERO;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         adj_reg <= `RST_ADJUST;
         fr2_reg <= `RST_FREQ2;
         fr1_reg <= `RST_FREQ1;
         fr0_reg <= `RST_FREQ0;
         pw_reg <= `RST_ZERO;
         cf1a_reg <= `RST_ZERO;
         cf1b_reg <= `RST_ZERO;
         cf2a_reg <= `RST_ZERO;
         cf2b_reg <= `RST_ZERO;
         cctl_reg <= `RST_ZERO;
         hlo_reg <= `RST_HSOFF_LO;
         hhi_reg <= `RST_ZERO;
         sl1_reg <= `RST_ZERO;
         sl2_reg <= `RST_ZERO;
         gps_reg <= `RST_ZERO;
      end else begin
         if (w_adj) adj_reg <= reg_wdata;
         if (w_fr2) fr2_reg <= reg_wdata;
         if (w_fr1) fr1_reg <= reg_wdata;
         if (w_fr0) fr0_reg <= reg_wdata;
         if (w_pw) pw_reg <= reg_wdata;
         if (w_c1a) cf1a_reg <= reg_wdata & `MASK_CAP_DATA;
         if (w_c1b) cf1b_reg <= reg_wdata & `MASK_CAP_DATA;
         if (w_c2a) cf2a_reg <= reg_wdata & `MASK_CAP_DATA;
         if (w_c2b) cf2b_reg <= reg_wdata & `MASK_CAP_DATA;
         if (w_cct) cctl_reg <= reg_wdata & `MASK_CAP_CTL;
         if (w_hlo) hlo_reg <= reg_wdata;
         if (w_hhi) hhi_reg <= reg_wdata & `MASK_HI2;
         if (w_sl1) sl1_reg <= reg_wdata;
         if (w_sl2) sl2_reg <= reg_wdata;
         if (w_gps) gps_reg <= reg_wdata;
      end
   end
   // timing counters and registered outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pix_reg <= 11'h0;
         line_reg <= 10'h0;
         rdata_reg <= `RST_ZERO;
         le_reg <= 1'b0;
         ph_reg <= '0;
      end else begin
         pix_reg <= pix_next;
         line_reg <= line_next;
         rdata_reg <= rdata_next;
         le_reg <= line_end;
         ph_reg <= ph_w;
      end
   end
   assign reg_rdata = rdata_reg;
   assign subcarrier_phase = ph_reg;
   assign line_end_out = le_reg;
   assign port_write_out = pw_reg;
   assign caption_control_out = cctl_reg;
   assign hsync_offset_out = {hhi_reg[1:0], hlo_reg};
   assign genlock_control_out = gps_reg;
   // cycles since the last line end, checked against the constants rather than line_len;
   // a format change voids the count until the next line end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_reg <= '0;
         run_ok_reg <= 1'b0;
         fmt_reg <= '0;
      end else begin
         run_reg <= line_end ? '0 : run_reg + 11'd1;
         fmt_reg <= video_format;
         if (line_end) begin
            run_ok_reg <= 1'b1;
         end else if (video_format != fmt_reg) begin
            run_ok_reg <= 1'b0;
         end
      end
   end
   sequence s_ntsc_line_end;
      line_end && is_ntsc && !cfg.line_reset_disable;
   endsequence
   a_line_length: assert property (@(posedge ref_clk) disable iff (rst)
      line_end && run_ok_reg && video_format == fmt_reg |->
      run_reg == (is_ntsc ? `PIX_PER_LINE_525 : `PIX_PER_LINE_625) - 11'd1)
      else $error("wrong line length");
   a_pix_wrap: assert property (@(posedge ref_clk) disable iff (rst)
      line_end |=> pix_reg == 11'h0) else $error("pixel count not wrapped");
   a_freq_msb: assert property (@(posedge ref_clk) disable iff (rst)
      w_fr2 |=> cfg.freq_word[23:16] == $past(reg_wdata)) else $error("msb not placed");
   a_freq_mid: assert property (@(posedge ref_clk) disable iff (rst)
      w_fr1 |=> cfg.freq_word[15:8] == $past(reg_wdata)) else $error("middle byte not placed");
   a_freq_lsb: assert property (@(posedge ref_clk) disable iff (rst)
      w_fr0 |=> cfg.freq_word[7:0] == $past(reg_wdata)) else $error("lsb not placed");
   a_adjust_seed: assert property (@(posedge ref_clk) disable iff (rst)
      w_adj |=> cfg.adjust == $past(reg_wdata)) else $error("adjust seed not taken");
   a_disable_set: assert property (@(posedge ref_clk) disable iff (rst)
      w_sl1 && reg_wdata[`BIT_LINE_RST_DIS] |=> cfg.line_reset_disable)
      else $error("disable not taken");
   a_disable_clear: assert property (@(posedge ref_clk) disable iff (rst)
      w_sl1 && !reg_wdata[`BIT_LINE_RST_DIS] |=> !cfg.line_reset_disable)
      else $error("disable not cleared");
   // phase output trails the accumulator by one flop, hence the extra cycle
   a_phase_restart: assert property (@(posedge ref_clk) disable iff (rst)
      s_ntsc_line_end |=> ##1 subcarrier_phase == '0)
      else $error("phase not restarted at line end");
endmodule // nco_upper_regs

// >>> verilog/subcarrier_nco.sv
// subcarrier phase accumulator with per-line reset and 8-field adjust
// assumes line_end and field_end pulses come from the timing generator
`timescale 1ns/100ps
`include "nco_consts.svh"
module subcarrier_nco import nco_pkg::*; #(
   parameter int PHASE_W = 10
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // configuration and timing
   input wire nco_cfg_s cfg,
   input wire logic line_end,
   input wire logic field_end,
   // phase out
   output logic [PHASE_W-1:0] phase
);
   logic [25:0] acc_reg;
   logic [25:0] acc_next;
   logic [2:0] fld_reg;
   logic [2:0] fld_next;
   wire adj_due = field_end && (fld_reg == `FIELDS_PER_ADJ);
   wire line_rst = cfg.is_ntsc && line_end && !cfg.line_reset_disable;
   wire [25:0] step = {2'b00, cfg.freq_word} +
      (adj_due ? {18'h0, cfg.adjust} : 26'h0);
   assign fld_next = field_end ? fld_reg + 3'd1 : fld_reg;
   assign acc_next = line_rst ? 26'h0 : acc_reg + step;
   assign phase = acc_reg[25 -: PHASE_W];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acc_reg <= 26'h0;
         fld_reg <= 3'h0;
      end else begin
         acc_reg <= acc_next;
         fld_reg <= fld_next;
      end
   end
   a_line_reset_zero: assert property (@(posedge ref_clk) disable iff (rst)
      line_rst |=> acc_reg == 26'h0) else $error("nco not reset at line end");
   a_adjust_once: assert property (@(posedge ref_clk) disable iff (rst)
      adj_due && !line_rst |=> acc_reg == $past(acc_reg) + $past(step))
      else $error("adjust add lost");
endmodule // subcarrier_nco
